/* File: core/dpc_pkg.sv */
// Shared constants for the signal-processing and pointer configuration block
package dpc_pkg;

  // ==========================================================
  // Register map (printed offsets are indexes, byte address = 4 x index)
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_CFG = 8'he2;
  localparam logic [7:0] IDX_WIN_LOW = 8'he4;
  localparam logic [7:0] IDX_WIN_HIGH = 8'he5;
  localparam logic [7:0] IDX_STATUS = 8'he7;
  localparam logic [ADDR_W-1:0] ADDR_CFG = {2'h0, IDX_CFG, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_WIN_LOW = {2'h0, IDX_WIN_LOW, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_WIN_HIGH = {2'h0, IDX_WIN_HIGH, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

  // ==========================================================
  // Configuration register fields
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int BIT_WIN = 6;
  localparam int BIT_SGN_B = 5;
  localparam int BIT_SGN_A = 4;
  localparam int BIT_CIRC1 = 3;
  localparam int BIT_CIRC0 = 2;
  localparam int BIT_IDX_DIS = 1;
  localparam int BIT_REDIR_B = 0;

  // Status register fields
  localparam int BIT_ST_PREFIX = 0;
  localparam int BIT_ST_LAST_PTR = 1;

  // ==========================================================
  // Accumulator result geometry
  localparam int MAC_W = 40;
  localparam int WIN_W = 2;
  localparam int BYTE_IDX_W = 3;
  localparam logic [WIN_W-1:0] WIN_FIXED_POINT = 2'h2;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_PREFIX = 8'ha5;
  localparam logic [7:0] OP_LOAD_PTR = 8'h90;
  localparam logic [7:0] OP_INC_PTR = 8'ha3;
  localparam logic [7:0] OP_CODE_READ = 8'h93;
  localparam logic [7:0] OP_XDATA_RD = 8'he0;
  localparam logic [7:0] OP_XDATA_WR = 8'hf0;
  localparam logic [7:0] OP_JMP_IDX = 8'h73;
  localparam logic [7:0] OP_MUL = 8'ha4;
  localparam logic [7:0] OP_MAC = 8'ha4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PREFIX = 2'b10
  } dpc_pfx_t;

endpackage

/* File: core/dpc_dec_if.sv */
// Carrier between the top block and the instruction decoder
`timescale 1ns/1ns
interface dpc_dec_if;
  logic instr_valid;
  logic [7:0] instr_byte;
  logic pointer_select;
  logic [7:0] cfg;
  logic prefix_pending;
  logic dec_valid;
  logic ptr_one;
  logic circular;
  logic code_read;
  logic use_index;
  logic xdata_rd;
  logic xdata_wr;
  logic data_to_b;
  logic inc_ptr;
  logic load_ptr;
  logic jmp_idx;
  logic mul;
  logic mul_a_signed;
  logic mul_b_signed;
  logic mac;

  modport top (
    output instr_valid, instr_byte, pointer_select, cfg,
    input prefix_pending, dec_valid, ptr_one, circular, code_read, use_index, xdata_rd, xdata_wr,
    input data_to_b, inc_ptr, load_ptr, jmp_idx, mul, mul_a_signed, mul_b_signed, mac
  );
  modport dec (
    input instr_valid, instr_byte, pointer_select, cfg,
    output prefix_pending, dec_valid, ptr_one, circular, code_read, use_index, xdata_rd, xdata_wr,
    output data_to_b, inc_ptr, load_ptr, jmp_idx, mul, mul_a_signed, mul_b_signed, mac
  );
endinterface

/* File: core/dpc_decode.sv */
// Instruction decoder for pointer selection, prefix inversion and multiply signedness
`timescale 1ns/1ns
module dpc_decode (
  input wire logic clk,
  input wire logic nrst,
  dpc_dec_if.dec dif
);

  // ==========================================================
  // Prefix tracking
  dpc_pkg::dpc_pfx_t state_q;
  dpc_pkg::dpc_pfx_t state_d;
  wire is_prefix_byte = dif.instr_byte == dpc_pkg::OP_PREFIX;
  wire in_prefix = state_q == dpc_pkg::ST_PREFIX;

  // The byte after a prefix is always consumed, so a doubled prefix cannot chain
  always_comb begin
    state_d = state_q;
    if (dif.instr_valid) begin
      unique case (state_q)
        dpc_pkg::ST_IDLE: state_d = is_prefix_byte ? dpc_pkg::ST_PREFIX : dpc_pkg::ST_IDLE;
        dpc_pkg::ST_PREFIX: state_d = dpc_pkg::ST_IDLE;
        default: state_d = dpc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= dpc_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Opcode classes
  wire op_live = dif.instr_valid && !(is_prefix_byte && !in_prefix);
  wire is_load = dif.instr_byte == dpc_pkg::OP_LOAD_PTR;
  wire is_inc = dif.instr_byte == dpc_pkg::OP_INC_PTR;
  wire is_code = dif.instr_byte == dpc_pkg::OP_CODE_READ;
  wire is_xrd = dif.instr_byte == dpc_pkg::OP_XDATA_RD;
  wire is_xwr = dif.instr_byte == dpc_pkg::OP_XDATA_WR;
  wire is_jmp = dif.instr_byte == dpc_pkg::OP_JMP_IDX;
  wire is_mul = !in_prefix && dif.instr_byte == dpc_pkg::OP_MUL;
  wire is_mac = in_prefix && dif.instr_byte == dpc_pkg::OP_MAC;

  // Generic pointer follows the select bit; prefix inverts it except for the indexed jump
  wire sel_ptr = is_jmp ? dif.pointer_select : (dif.pointer_select ^ in_prefix);

  assign dif.prefix_pending = in_prefix;
  assign dif.dec_valid = op_live;
  assign dif.ptr_one = sel_ptr;
  assign dif.circular = sel_ptr ? dif.cfg[dpc_pkg::BIT_CIRC1] : dif.cfg[dpc_pkg::BIT_CIRC0];
  assign dif.code_read = op_live && is_code;
  // Index register stays the accumulator whatever the redirect bit says
  assign dif.use_index = op_live && is_code && !dif.cfg[dpc_pkg::BIT_IDX_DIS];
  assign dif.xdata_rd = op_live && is_xrd;
  assign dif.xdata_wr = op_live && is_xwr;
  assign dif.data_to_b = op_live && sel_ptr && (is_code || is_xrd || is_xwr) && dif.cfg[dpc_pkg::BIT_REDIR_B];
  assign dif.inc_ptr = op_live && is_inc;
  assign dif.load_ptr = op_live && is_load;
  assign dif.jmp_idx = op_live && is_jmp;
  assign dif.mul = op_live && is_mul;
  // Sign bits reach the multiplier only for the plain multiply, never for the accumulate
  assign dif.mul_a_signed = op_live && is_mul && dif.cfg[dpc_pkg::BIT_SGN_A];
  assign dif.mul_b_signed = op_live && is_mul && dif.cfg[dpc_pkg::BIT_SGN_B];
  assign dif.mac = op_live && is_mac;

endmodule

/* File: core/dpc_top.sv */
// Signal-processing and pointer configuration register with instruction decode
`timescale 1ns/1ns

// Summary of operation
// - Window-select field picks which adjacent byte pair shows at the window addresses.
// - Window-select 10 shows the fixed-point segment, dropping the lowest fraction bytes.
// - Operand-B sign bit makes the plain multiply treat B as signed.
// - Operand-A sign bit makes the plain multiply treat the accumulator as signed.
// - Both sign bits are ignored by the multiply-accumulate instruction.
// - Pointer-1 circular bit makes pointer 1 wrap over the circular ranges.
// - Pointer-0 circular bit makes pointer 0 wrap over the circular ranges.
// - Index disable bit makes the indexed code read use the pointer alone.
// - Redirect bit moves pointer-1 code and external data transfers to B.
// - Redirect bit never changes the index register of indexed code reads.
// - A prefix byte inverts the pointer-select bit for the very next instruction byte, except an indexed jump.
// - Pointer-select bit chooses the pointer for generic pointer instructions.
// - The 40-bit result is reached only through a sliding 16-bit window.
// - Multiply-accumulate always multiplies signed by signed.
module dpc_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dpc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [dpc_pkg::MAC_W-1:0] mac_result,
  output logic mac_wr_valid,
  output logic [dpc_pkg::BYTE_IDX_W-1:0] mac_wr_byte,
  output logic [7:0] mac_wr_data,
  input wire logic instr_valid,
  input wire logic [7:0] instr_byte,
  input wire logic pointer_select,
  output logic [dpc_pkg::WIN_W-1:0] result_window_select,
  output logic ptr1_circular_enable,
  output logic ptr0_circular_enable,
  output logic code_read_index_disable,
  output logic ptr1_redirect_to_b,
  output logic op_valid,
  output logic op_ptr_one,
  output logic op_circular,
  output logic op_code_read,
  output logic op_use_index,
  output logic op_xdata_rd,
  output logic op_xdata_wr,
  output logic op_data_to_b,
  output logic op_inc_ptr,
  output logic op_load_ptr,
  output logic op_jmp_idx,
  output logic op_mul,
  output logic op_mul_a_signed,
  output logic op_mul_b_signed,
  output logic op_mac,
  output logic op_mac_signed
);

  // ==========================================================
  // Helpers
  function automatic logic [dpc_pkg::BYTE_IDX_W-1:0] win_byte_idx(input logic [dpc_pkg::WIN_W-1:0] w,
                                                                  input logic hi);
    win_byte_idx = {1'b0, w} + {2'h0, hi};
  endfunction

  function automatic logic [7:0] mac_byte(input logic [dpc_pkg::MAC_W-1:0] m,
                                          input logic [dpc_pkg::BYTE_IDX_W-1:0] idx);
    mac_byte = m[{idx, 3'h0} +: 8];
  endfunction

  // ==========================================================
  // Registers
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pslverr_q;
  logic pslverr_d;
  logic mac_wr_valid_q;
  logic [dpc_pkg::BYTE_IDX_W-1:0] mac_wr_byte_q;
  logic [7:0] mac_wr_data_q;
  logic last_ptr_q;

  dpc_dec_if dif ();

  // ==========================================================
  // APB decode
  wire access = psel && penable;
  wire first_access = access && !pready_q;
  wire done = access && pready_q;
  wire hit_cfg = paddr == dpc_pkg::ADDR_CFG;
  wire hit_low = paddr == dpc_pkg::ADDR_WIN_LOW;
  wire hit_high = paddr == dpc_pkg::ADDR_WIN_HIGH;
  wire hit_stat = paddr == dpc_pkg::ADDR_STATUS;
  wire hit_any = hit_cfg || hit_low || hit_high || hit_stat;
  wire wr_lane0 = pwrite && pstrb[0];
  // Status is read only; a write there is refused like an unmapped address
  wire bad = !hit_any || (pwrite && hit_stat);
  wire do_cfg_wr = done && wr_lane0 && hit_cfg;
  wire do_win_wr = done && wr_lane0 && (hit_low || hit_high);

  wire [dpc_pkg::WIN_W-1:0] win_sel = cfg_q[dpc_pkg::BIT_WIN +: dpc_pkg::WIN_W];
  wire [dpc_pkg::BYTE_IDX_W-1:0] low_idx = win_byte_idx(win_sel, 1'b0);
  wire [dpc_pkg::BYTE_IDX_W-1:0] high_idx = win_byte_idx(win_sel, 1'b1);
  wire [dpc_pkg::BYTE_IDX_W-1:0] wr_idx = hit_high ? high_idx : low_idx;
  wire [7:0] status_val = {6'h00, last_ptr_q, dif.prefix_pending};

  always_comb begin
    prdata_d = 32'h0000_0000;
    if (hit_cfg) begin
      prdata_d = {24'h00_0000, cfg_q};
    end else if (hit_low) begin
      prdata_d = {24'h00_0000, mac_byte(mac_result, low_idx)};
    end else if (hit_high) begin
      prdata_d = {24'h00_0000, mac_byte(mac_result, high_idx)};
    end else if (hit_stat) begin
      prdata_d = {24'h00_0000, status_val};
    end
  end

  always_comb begin
    cfg_d = cfg_q;
    if (do_cfg_wr) begin
      cfg_d = pwdata[7:0];
    end
  end

  assign pslverr_d = bad;

  // One wait state so read data comes straight from a flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= first_access;
      pslverr_q <= first_access && pslverr_d;
      prdata_q <= (first_access && !pwrite) ? prdata_d : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= dpc_pkg::CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ==========================================================
  // Window writes go to the result datapath as byte strobes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mac_wr_valid_q <= 1'b0;
      mac_wr_byte_q <= '0;
      mac_wr_data_q <= 8'h00;
    end else begin
      mac_wr_valid_q <= do_win_wr;
      if (do_win_wr) begin
        mac_wr_byte_q <= wr_idx;
        mac_wr_data_q <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // Decoder
  assign dif.instr_valid = instr_valid;
  assign dif.instr_byte = instr_byte;
  assign dif.pointer_select = pointer_select;
  assign dif.cfg = cfg_q;

  dpc_decode u_dec (
    .clk(clk),
    .nrst(nrst),
    .dif(dif)
  );

  // Decoded strobes are registered, so they lag the opcode by one cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_valid <= 1'b0;
      op_ptr_one <= 1'b0;
      op_circular <= 1'b0;
      op_code_read <= 1'b0;
      op_use_index <= 1'b0;
      op_xdata_rd <= 1'b0;
      op_xdata_wr <= 1'b0;
      op_data_to_b <= 1'b0;
      op_inc_ptr <= 1'b0;
      op_load_ptr <= 1'b0;
      op_jmp_idx <= 1'b0;
      op_mul <= 1'b0;
      op_mul_a_signed <= 1'b0;
      op_mul_b_signed <= 1'b0;
      op_mac <= 1'b0;
      op_mac_signed <= 1'b0;
      last_ptr_q <= 1'b0;
    end else begin
      op_valid <= dif.dec_valid;
      op_ptr_one <= dif.dec_valid && dif.ptr_one;
      op_circular <= dif.dec_valid && dif.circular;
      op_code_read <= dif.code_read;
      op_use_index <= dif.use_index;
      op_xdata_rd <= dif.xdata_rd;
      op_xdata_wr <= dif.xdata_wr;
      op_data_to_b <= dif.data_to_b;
      op_inc_ptr <= dif.inc_ptr;
      op_load_ptr <= dif.load_ptr;
      op_jmp_idx <= dif.jmp_idx;
      op_mul <= dif.mul;
      op_mul_a_signed <= dif.mul_a_signed;
      op_mul_b_signed <= dif.mul_b_signed;
      op_mac <= dif.mac;
      op_mac_signed <= dif.mac;
      if (dif.dec_valid) begin
        last_ptr_q <= dif.ptr_one;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mac_wr_valid = mac_wr_valid_q;
  assign mac_wr_byte = mac_wr_byte_q;
  assign mac_wr_data = mac_wr_data_q;
  assign result_window_select = win_sel;
  assign ptr1_circular_enable = cfg_q[dpc_pkg::BIT_CIRC1];
  assign ptr0_circular_enable = cfg_q[dpc_pkg::BIT_CIRC0];
  assign code_read_index_disable = cfg_q[dpc_pkg::BIT_IDX_DIS];
  assign ptr1_redirect_to_b = cfg_q[dpc_pkg::BIT_REDIR_B];

endmodule

/* File: testbench/dpc_top_asserts.sv */
// Checker for the configuration register and pointer decode block
`timescale 1ns/1ns
module dpc_top_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dpc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [dpc_pkg::MAC_W-1:0] mac_result,
  input wire logic mac_wr_valid,
  input wire logic [dpc_pkg::BYTE_IDX_W-1:0] mac_wr_byte,
  input wire logic [7:0] mac_wr_data,
  input wire logic instr_valid,
  input wire logic [7:0] instr_byte,
  input wire logic pointer_select,
  input wire logic [dpc_pkg::WIN_W-1:0] result_window_select,
  input wire logic ptr1_circular_enable,
  input wire logic ptr0_circular_enable,
  input wire logic code_read_index_disable,
  input wire logic ptr1_redirect_to_b,
  input wire logic op_ptr_one,
  input wire logic op_use_index,
  input wire logic op_data_to_b,
  input wire logic op_inc_ptr,
  input wire logic op_jmp_idx,
  input wire logic op_mul,
  input wire logic op_mul_a_signed,
  input wire logic op_mul_b_signed,
  input wire logic op_mac,
  input wire logic op_mac_signed
);
  // ==========================================================
  // Shadow state
  logic pfx_q;
  logic [7:0] cfg_q;
  wire acc_done = psel & penable & pready;
  wire wr_ok = acc_done & pwrite & pstrb[0];
  wire [2:0] w_lo = {1'b0, result_window_select};
  wire [2:0] w_hi = w_lo + 3'h1;
  wire [7:0] lo_b = mac_result[8*w_lo +: 8];
  wire [7:0] hi_b = mac_result[8*w_hi +: 8];
  wire mapped = paddr == dpc_pkg::ADDR_CFG || paddr == dpc_pkg::ADDR_WIN_LOW || paddr == dpc_pkg::ADDR_WIN_HIGH
    || (paddr == dpc_pkg::ADDR_STATUS && !pwrite);
  wire idx_dis = cfg_q[dpc_pkg::BIT_IDX_DIS];
  wire redir = cfg_q[dpc_pkg::BIT_REDIR_B];
  wire sgn_a = cfg_q[dpc_pkg::BIT_SGN_A];
  wire sgn_b = cfg_q[dpc_pkg::BIT_SGN_B];
  wire cfg_wr = wr_ok && paddr == dpc_pkg::ADDR_CFG;
  wire hi_wr = wr_ok && paddr == dpc_pkg::ADDR_WIN_HIGH;
  wire rd_done = acc_done && !pwrite;
  wire [3:0] ptr_bits = {ptr1_circular_enable, ptr0_circular_enable, code_read_index_disable, ptr1_redirect_to_b};
  wire mul_byte = instr_valid && instr_byte == dpc_pkg::OP_MUL;
  wire code_byte = instr_valid && instr_byte == dpc_pkg::OP_CODE_READ;
  // Pointer the rules ask for, worked out from the shadow prefix state
  wire exp_ptr = pointer_select ^ pfx_q;

  // A prefix arms only when it is not itself the byte after a prefix
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pfx_q <= 1'b0;
      cfg_q <= dpc_pkg::CFG_RESET;
    end else begin
      if (instr_valid)
        pfx_q <= !pfx_q && instr_byte == dpc_pkg::OP_PREFIX;
      if (wr_ok && paddr == dpc_pkg::ADDR_CFG)
        cfg_q <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_WIN_CFG: assert property (cfg_wr |=> result_window_select == $past(pwdata[7:6]))
    else $error("window select not loaded");
  AST_PTR_CFG: assert property (cfg_wr |=> ptr_bits == $past(pwdata[3:0]))
    else $error("pointer bits not loaded");
  AST_WIN_RD_LO: assert property (rd_done && paddr == dpc_pkg::ADDR_WIN_LOW |-> prdata == {24'h0, lo_b})
    else $error("low window byte wrong");
  AST_WIN_RD_HI: assert property (rd_done && paddr == dpc_pkg::ADDR_WIN_HIGH |-> prdata == {24'h0, hi_b})
    else $error("high window byte wrong");
  AST_MAP_ERR: assert property (acc_done |-> pslverr == !mapped)
    else $error("error response wrong");
  AST_WIN_WR: assert property (hi_wr |=> mac_wr_valid && mac_wr_byte == $past(w_hi)
    && mac_wr_data == $past(pwdata[7:0])) else $error("window write strobe wrong");
  AST_PFX_INV: assert property (instr_valid && instr_byte == dpc_pkg::OP_INC_PTR |=> op_inc_ptr
    && op_ptr_one == $past(exp_ptr)) else $error("pointer choice wrong");
  AST_JMP_NOINV: assert property (instr_valid && instr_byte == dpc_pkg::OP_JMP_IDX |=> op_jmp_idx
    && op_ptr_one == $past(pointer_select)) else $error("indexed jump pointer wrong");
  AST_CODE_RD: assert property (code_byte |=> op_use_index == !$past(idx_dis)
    && op_data_to_b == $past(redir && exp_ptr)) else $error("code read decode wrong");
  AST_MUL_SGN: assert property (mul_byte && !pfx_q |=> op_mul && !op_mac
    && op_mul_a_signed == $past(sgn_a) && op_mul_b_signed == $past(sgn_b)) else $error("multiply sign wrong");
  AST_MAC: assert property (mul_byte && pfx_q |=> op_mac && op_mac_signed
    && !op_mul && !op_mul_a_signed && !op_mul_b_signed) else $error("accumulate decode wrong");

  cover property (instr_valid && instr_byte == dpc_pkg::OP_INC_PTR && pfx_q);
  cover property (acc_done && pslverr);
  cover property (wr_ok && paddr == dpc_pkg::ADDR_WIN_HIGH);
endmodule

bind dpc_top dpc_top_asserts u_chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mac_result(mac_result), .mac_wr_valid(mac_wr_valid), .mac_wr_byte(mac_wr_byte), .mac_wr_data(mac_wr_data),
  .instr_valid(instr_valid), .instr_byte(instr_byte), .pointer_select(pointer_select),
  .result_window_select(result_window_select), .ptr1_circular_enable(ptr1_circular_enable),
  .ptr0_circular_enable(ptr0_circular_enable), .code_read_index_disable(code_read_index_disable),
  .ptr1_redirect_to_b(ptr1_redirect_to_b), .op_ptr_one(op_ptr_one), .op_use_index(op_use_index),
  .op_data_to_b(op_data_to_b), .op_inc_ptr(op_inc_ptr), .op_jmp_idx(op_jmp_idx), .op_mul(op_mul),
  .op_mul_a_signed(op_mul_a_signed), .op_mul_b_signed(op_mul_b_signed), .op_mac(op_mac), .op_mac_signed(op_mac_signed));

/* File: testbench/dsp_config_and_dptr_select_test.sv */
// Self-checking bench for the configuration register and pointer decode block
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module dsp_config_and_dptr_select_test;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, instr_valid = 1'b0, pointer_select = 1'b0;
  logic [dpc_pkg::ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [39:0] mac_result = 40'h0;
  logic [7:0] instr_byte = 8'h00, mac_wr_data, cfg_m = 8'h00;
  logic pready, pslverr, mac_wr_valid, err, pfx_m = 1'b0;
  logic [2:0] mac_wr_byte;
  logic [1:0] result_window_select;
  logic ptr1_circular_enable, ptr0_circular_enable, code_read_index_disable, ptr1_redirect_to_b;
  logic op_valid, op_ptr_one, op_circular, op_code_read, op_use_index, op_xdata_rd, op_xdata_wr, op_data_to_b;
  logic op_inc_ptr, op_load_ptr, op_jmp_idx, op_mul, op_mul_a_signed, op_mul_b_signed, op_mac, op_mac_signed;
  int n_mismatch = 0, checks_done = 0, cycles = 0;
  logic [31:0] lfsr_q = 32'h0001592d;
  logic [7:0] ops [8] = '{dpc_pkg::OP_LOAD_PTR, dpc_pkg::OP_INC_PTR, dpc_pkg::OP_CODE_READ, dpc_pkg::OP_XDATA_RD,
    dpc_pkg::OP_XDATA_WR, dpc_pkg::OP_JMP_IDX, dpc_pkg::OP_MUL, dpc_pkg::OP_PREFIX};

  always #5 clk = ~clk;

  dpc_top uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mac_result(mac_result),
    .mac_wr_valid(mac_wr_valid), .mac_wr_byte(mac_wr_byte), .mac_wr_data(mac_wr_data), .instr_valid(instr_valid),
    .instr_byte(instr_byte), .pointer_select(pointer_select), .result_window_select(result_window_select),
    .ptr1_circular_enable(ptr1_circular_enable), .ptr0_circular_enable(ptr0_circular_enable),
    .code_read_index_disable(code_read_index_disable), .ptr1_redirect_to_b(ptr1_redirect_to_b),
    .op_valid(op_valid), .op_ptr_one(op_ptr_one), .op_circular(op_circular), .op_code_read(op_code_read),
    .op_use_index(op_use_index), .op_xdata_rd(op_xdata_rd), .op_xdata_wr(op_xdata_wr), .op_data_to_b(op_data_to_b),
    .op_inc_ptr(op_inc_ptr), .op_load_ptr(op_load_ptr), .op_jmp_idx(op_jmp_idx), .op_mul(op_mul),
    .op_mul_a_signed(op_mul_a_signed), .op_mul_b_signed(op_mul_b_signed), .op_mac(op_mac), .op_mac_signed(op_mac_signed));

  // ==========================================================
  // Expectation helpers
  function logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Top bit flags a pointer instruction; pointer fields mean nothing for the others
  function logic [16:0] exp_ops(input logic [7:0] b, input logic p, input logic pf, input logic [7:0] c);
    logic pt, po, mv, mc, cr, rw;
    pt = b inside {dpc_pkg::OP_LOAD_PTR, dpc_pkg::OP_INC_PTR, dpc_pkg::OP_CODE_READ, dpc_pkg::OP_XDATA_RD,
      dpc_pkg::OP_XDATA_WR, dpc_pkg::OP_JMP_IDX};
    po = p ^ (pf && b != dpc_pkg::OP_JMP_IDX);
    mv = b == dpc_pkg::OP_MUL && !pf;
    mc = b == dpc_pkg::OP_MUL && pf;
    cr = b == dpc_pkg::OP_CODE_READ;
    rw = cr || b == dpc_pkg::OP_XDATA_RD || b == dpc_pkg::OP_XDATA_WR;
    return {pt, !(b == dpc_pkg::OP_PREFIX && !pf), pt & po, pt & (po ? c[dpc_pkg::BIT_CIRC1] : c[dpc_pkg::BIT_CIRC0]),
      cr, cr & !c[dpc_pkg::BIT_IDX_DIS], rw & po & c[dpc_pkg::BIT_REDIR_B], b == dpc_pkg::OP_INC_PTR,
      b == dpc_pkg::OP_LOAD_PTR, b == dpc_pkg::OP_XDATA_RD, b == dpc_pkg::OP_XDATA_WR, b == dpc_pkg::OP_JMP_IDX,
      mv, mv & c[dpc_pkg::BIT_SGN_A], mv & c[dpc_pkg::BIT_SGN_B], mc, mc};
  endfunction

  // ==========================================================
  // Drivers
  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] st);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task setcfg(input logic [7:0] v);
    logic [5:0] got;
    apb(1'b1, dpc_pkg::ADDR_CFG, v, 4'h1);
    cfg_m = v;
    @(negedge clk);
    got = {result_window_select, ptr1_circular_enable, ptr0_circular_enable, code_read_index_disable,
      ptr1_redirect_to_b};
    `CHK(got, {v[7:6], v[3:0]})
  endtask

  task ins(input logic [7:0] b, input logic p);
    logic [16:0] e;
    logic [15:0] got;
    e = exp_ops(b, p, pfx_m, cfg_m);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_byte <= b;
    pointer_select <= p;
    @(posedge clk);
    instr_valid <= 1'b0;
    pfx_m = !pfx_m && b == dpc_pkg::OP_PREFIX;
    @(negedge clk);
    got = {op_valid, op_ptr_one & e[16], op_circular & e[16], op_code_read, op_use_index, op_data_to_b,
      op_inc_ptr, op_load_ptr, op_xdata_rd, op_xdata_wr, op_jmp_idx, op_mul, op_mul_a_signed, op_mul_b_signed,
      op_mac, op_mac_signed};
    `CHK(got, e[15:0])
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard sized well above the expected run of about a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run;
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, dpc_pkg::ADDR_CFG, 8'h00, 4'hf);
    `CHK(rd, 32'h0)
    for (int w = 0; w < 4; w++) begin
      lfsr_q = lfsr_next(lfsr_q);
      @(posedge clk);
      mac_result <= {lfsr_q, lfsr_q[23:16]};
      setcfg({w[1:0], lfsr_q[5:0]});
      apb(1'b0, dpc_pkg::ADDR_WIN_LOW, 8'h00, 4'hf);
      `CHK(rd, {24'h0, mac_result[8*w +: 8]})
      apb(1'b0, dpc_pkg::ADDR_WIN_HIGH, 8'h00, 4'hf);
      `CHK(rd, {24'h0, mac_result[8*(w+1) +: 8]})
      apb(1'b1, dpc_pkg::ADDR_WIN_HIGH, lfsr_q[15:8], 4'h1);
      @(negedge clk);
      `CHK({mac_wr_valid, mac_wr_byte, mac_wr_data}, {1'b1, 3'(w + 1), lfsr_q[15:8]})
    end
    // Cleared byte strobe leaves the register alone
    apb(1'b1, dpc_pkg::ADDR_CFG, ~cfg_m, 4'h0);
    apb(1'b0, dpc_pkg::ADDR_CFG, 8'h00, 4'hf);
    `CHK(rd, {24'h0, cfg_m})
    apb(1'b0, 12'h3a0, 8'h00, 4'hf);
    `CHK(err, 1'b1)
    apb(1'b1, dpc_pkg::ADDR_STATUS, 8'hff, 4'hf);
    `CHK(err, 1'b1)
    // Prefix corners: inverted increment, jump untouched, double prefix, prefixed multiply
    setcfg(8'h3d);
    ins(dpc_pkg::OP_PREFIX, 1'b0);
    // A register access in between must not disturb the pending prefix
    apb(1'b0, dpc_pkg::ADDR_STATUS, 8'h00, 4'hf);
    `CHK(rd, 32'h1)
    ins(dpc_pkg::OP_INC_PTR, 1'b0);
    ins(dpc_pkg::OP_PREFIX, 1'b1);
    ins(dpc_pkg::OP_JMP_IDX, 1'b1);
    ins(dpc_pkg::OP_MUL, 1'b0);
    ins(dpc_pkg::OP_PREFIX, 1'b0);
    ins(dpc_pkg::OP_PREFIX, 1'b0);
    ins(dpc_pkg::OP_PREFIX, 1'b0);
    ins(dpc_pkg::OP_MUL, 1'b0);
    for (int i = 0; i < 400; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      if (i % 40 == 0)
        setcfg(lfsr_q[31:24]);
      ins(ops[lfsr_q[2:0]], lfsr_q[3]);
    end
    complete_run;
  end
endmodule
